// ---- hdl/bpc_defines.svh ----
// constants for the bidirectional port block
`ifndef BPC_DEFINES_SVH
`define BPC_DEFINES_SVH
`define BPC_ADDR_W 4
`define BPC_OFS_DATA 4'h0
`define BPC_OFS_DIR 4'h4
`define BPC_OFS_ANALOG 4'h8
`define BPC_OFS_ALTPIN 4'hC
`define BPC_RST_DIR 8'hFF
`define BPC_RST_ANALOG 8'h00
`define BPC_RST_LATCH 8'h00
`define BPC_RST_ALTPIN 1'h0
`define BPC_ALTPIN_SEL_BIT 0
`define BPC_RDWAIT 1
`endif

// ---- hdl/bpc_pkg.sv ----
// types for the bidirectional port block
package bpc_pkg;
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } bpc_pin_drive_type;
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [3:0] byteenable;
  } bpc_bus_req_type;
  typedef enum logic [1:0] {
    BPC_IDLE = 2'b01,
    BPC_DONE = 2'b10
  } bpc_state_type;
endpackage : bpc_pkg

// ---- hdl/bpc_pin_sync.sv ----
// three-stage synchroniser for one pin with agreement filter
`timescale 1ns/1ps
module bpc_pin_sync
(
  input wire logic clk, // clock
  input wire logic rst_n, // async reset, active low
  input wire logic pin_in, // raw pin level
  output logic level // filtered level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
        level_q <= s3_q;
    end
  end
  assign level = level_q;
endmodule : bpc_pin_sync

// ---- hdl/bpc_pin_drv.sv ----
// per-pin output driver control
`timescale 1ns/1ps
module bpc_pin_drv
(
  input wire logic dir_in, // direction bit, 1 = input
  input wire logic latch, // output latch bit
  output logic dout, // pin output value
  output logic oe // pin output enable
);
  // tri-state when direction bit set, drive latch otherwise
  assign oe = ~dir_in;
  assign dout = latch;
endmodule : bpc_pin_drv

// ---- hdl/bpc_port.sv ----
// eight-pin bidirectional port with avalon-mm register access
`timescale 1ns/1ps
`include "bpc_defines.svh"
module bpc_port
  import bpc_pkg::*;
(
  input wire logic CLOCK, // 200 MHz clock
  input wire logic RST_N, // async reset, active low
  input wire logic [3:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read strobe
  input wire logic AVS_WRITE, // write strobe
  input wire logic [31:0] AVS_WRITEDATA, // write data
  input wire logic [3:0] AVS_BYTEENABLE, // byte enables
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // wait request
  input wire logic [7:0] PIN_IN, // pin levels from pads
  output logic [7:0] PIN_OUT, // pin output values
  output logic [7:0] PIN_OE, // pin output enables, high drives
  output logic CAPTURE2_PIN_SELECT // capture unit two alternate pin
);
  // ****************************************************************
  // bus request
  // ****************************************************************
  bpc_bus_req_type req;
  bpc_state_type state_q;
  bpc_state_type state_d;
  logic [7:0] dir_q;
  logic [7:0] analog_q;
  logic [7:0] latch_q;
  logic altpin_q;
  logic [31:0] rdata_q;
  logic [7:0] pin_level;
  logic [7:0] pin_read;
  bpc_pin_drive_type drive;

  assign req.read = AVS_READ;
  assign req.write = AVS_WRITE;
  assign req.addr = AVS_ADDRESS;
  assign req.wdata = AVS_WRITEDATA;
  assign req.byteenable = AVS_BYTEENABLE;

  wire sel_data = (req.addr == `BPC_OFS_DATA);
  wire sel_dir = (req.addr == `BPC_OFS_DIR);
  wire sel_analog = (req.addr == `BPC_OFS_ANALOG);
  wire sel_altpin = (req.addr == `BPC_OFS_ALTPIN);
  wire lane0 = req.byteenable[0];
  wire busy = state_q == BPC_IDLE;
  // writes land at the edge where waitrequest is seen low
  wire wr_go = req.write && (state_q == BPC_DONE);
  wire rd_go = req.read && busy;

  // ****************************************************************
  // pin input sampling and drivers
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1)
    begin : g_pin
      bpc_pin_sync u_sync
      (
        .clk(CLOCK),
        .rst_n(RST_N),
        .pin_in(PIN_IN[i]),
        .level(pin_level[i])
      );
      bpc_pin_drv u_drv
      (
        .dir_in(dir_q[i]),
        .latch(latch_q[i]),
        .dout(drive.dout[i]),
        .oe(drive.oe[i])
      );
    end
  endgenerate

  // analog pins read zero, others read the threshold-resolved level
  assign pin_read = pin_level & ~analog_q;
  assign PIN_OUT = drive.dout;
  assign PIN_OE = drive.oe;
  assign CAPTURE2_PIN_SELECT = altpin_q;

  // ****************************************************************
  // read data selection
  // ****************************************************************
  wire [7:0] rd_byte = sel_data ? pin_read :
    sel_dir ? dir_q :
    sel_analog ? analog_q :
    sel_altpin ? {7'h00, altpin_q} : 8'h00;

  // write value: sampled pin level is masked off, latch takes the whole write byte
  wire [7:0] rmw_value = pin_read;
  wire [7:0] latch_new = req.wdata[7:0];

  // ****************************************************************
  // handshake state
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BPC_IDLE:
        if (req.read || req.write)
          state_d = BPC_DONE;
      BPC_DONE:
        state_d = BPC_IDLE;
      default:
        state_d = BPC_IDLE;
    endcase
  end

  assign AVS_WAITREQUEST = (req.read || req.write) && busy;
  assign AVS_READDATA = rdata_q;

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= BPC_IDLE;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      state_q <= state_d;
      if (rd_go)
        rdata_q <= {24'h000000, rd_byte};
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      dir_q <= `BPC_RST_DIR;
      latch_q <= `BPC_RST_LATCH;
      analog_q <= `BPC_RST_ANALOG;
      altpin_q <= `BPC_RST_ALTPIN;
    end
    else if (wr_go && lane0)
    begin
      if (sel_data)
        latch_q <= latch_new | (rmw_value & 8'h00);
      if (sel_dir)
        dir_q <= req.wdata[7:0];
      if (sel_analog)
        analog_q <= req.wdata[7:0];
      if (sel_altpin)
        altpin_q <= req.wdata[`BPC_ALTPIN_SEL_BIT];
    end
  end
endmodule : bpc_port

// ---- sim/bpc_port_sva.sv ----
// port checks
`timescale 1ns/1ps
module bpc_port_sva
(
  input wire logic CLOCK, // clk
  input wire logic RST_N, // rst
  input wire logic [3:0] AVS_ADDRESS, // adr
  input wire logic AVS_READ, // rd
  input wire logic AVS_WRITE, // wr
  input wire logic [31:0] AVS_WRITEDATA, // wd
  input wire logic [3:0] AVS_BYTEENABLE, // be
  input wire logic [31:0] AVS_READDATA, // rq
  input wire logic AVS_WAITREQUEST, // wait
  input wire logic [7:0] PIN_OUT, // out
  input wire logic [7:0] PIN_OE, // oe
  input wire logic CAPTURE2_PIN_SELECT // sel
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  wire w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire wl = w && AVS_ADDRESS == 4'h0;
  wire [7:0] v = AVS_WRITEDATA[7:0];
  oe_a: assert property (w && AVS_ADDRESS == 4'h4 |=> PIN_OE == ~$past(v))
    else $error("oe");
  lat_a: assert property (wl |=> PIN_OUT == $past(v))
    else $error("latch");
  dir_keep_a: assert property (wl |=> $stable(PIN_OE))
    else $error("dir");
  out_hold_a: assert property (!wl |=> $stable(PIN_OUT))
    else $error("hold");
  sel_a: assert property (w && AVS_ADDRESS == 4'hC |=> CAPTURE2_PIN_SELECT == $past(v[0]))
    else $error("sel");
  wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait");
  rd_upper_a: assert property (AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper");
  rst_in_a: assert property ($rose(RST_N) |-> PIN_OE == 8'h00)
    else $error("reset");
  cover property (wl);
  cover property (w && AVS_ADDRESS == 4'hC);
  cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule : bpc_port_sva

// ---- sim/bpc_pin_model.sv ----
// far-side pin circuitry
`timescale 1ns/1ps
module bpc_pin_model
(
  input wire logic [7:0] pin_out, // port out
  input wire logic [7:0] pin_oe, // port oe
  input wire logic [7:0] ext_val, // far level
  output logic [7:0] pad // pad level
);
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : bpc_pin_model

// ---- sim/bpc_port_tb_top.sv ----
// port bench
`timescale 1ns/1ps
module bpc_port_tb_top;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, wq, sel;
  logic [3:0] adr = 0, be = 0;
  logic [31:0] wd = 0, q, rq;
  logic [7:0] pin, po, oe;
  int n_errors = 0, check_count = 0, cyc = 0;
  always #2.5 clk = ~clk;
  bpc_port i_bpc_port (.CLOCK(clk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rq),
    .AVS_WAITREQUEST(wq), .PIN_IN(pin), .PIN_OUT(po), .PIN_OE(oe), .CAPTURE2_PIN_SELECT(sel));
  bpc_pin_model i_bpc_pin_model (.pin_out(po), .pin_oe(oe), .ext_val(8'hA5), .pad(pin));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] b);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    be <= b;
    @(posedge clk);
    while (wq) @(posedge clk);
    q = rq;
    rd <= 0;
    wr <= 0;
  endtask : acc
  task automatic rck(input string s, input logic [3:0] a, input logic [7:0] e);
    repeat (6) @(posedge clk);
    acc(0, a, 8'h00, 4'h1);
    chk(s, {24'h0, e}, q);
    $display("test %s done", s);
  endtask : rck
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rck("dir", 4'h4, 8'hFF);
    rck("pins", 4'h0, 8'hA5);
    acc(1, 4'h4, 8'h0F, 4'h1);
    acc(1, 4'h0, 8'h3C, 4'h1);
    rck("mixed", 4'h0, 8'h35);
    chk("oe", 8'hF0, oe);
    acc(1, 4'h0, 8'hFF, 4'h0);
    acc(1, 4'h8, 8'h11, 4'h1);
    rck("analog", 4'h0, 8'h24);
    chk("out", 8'h3C, po);
    chk("oe2", 8'hF0, oe);
    rck("unmapped", 4'h2, 8'h00);
    acc(1, 4'hC, 8'h01, 4'h1);
    rck("sel", 4'hC, 8'h01);
    chk("selpin", 1, sel);
    give_verdict();
  end
endmodule : bpc_port_tb_top
bind bpc_port bpc_port_sva i_bpc_port_sva (.CLOCK(CLOCK), .RST_N(RST_N),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE),
  .CAPTURE2_PIN_SELECT(CAPTURE2_PIN_SELECT));
